// *** hdl/asct_pkg.sv ***
// Constants for the gain loop and VCO calibration test register bank
package asct_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] ADDR_GAIN_MODE_THR = 6'h24;
  localparam logic [5:0] ADDR_GAIN_LOOP_TUNE = 6'h25;
  localparam logic [5:0] ADDR_FE_GAIN_STEPS = 6'h26;
  localparam logic [5:0] ADDR_VCO_ARRAY_CAL = 6'h27;
  localparam logic [5:0] ADDR_VCO_CAL_CTRL = 6'h28;
  localparam logic [5:0] ADDR_VCO_CURR_CAL = 6'h29;
  localparam int N_REGS = 6;

  // ----------------------------------------
  // Reset values and writable bit masks
  // ----------------------------------------
  localparam logic [15:0] RST_GAIN_MODE_THR = 16'h3649;
  localparam logic [15:0] RST_GAIN_LOOP_TUNE = 16'h0854;
  localparam logic [15:0] RST_FE_GAIN_STEPS = 16'h012A;
  localparam logic [15:0] RST_VCO_ARRAY_CAL = 16'h0200;
  localparam logic [15:0] RST_VCO_CAL_CTRL = 16'h5002;
  localparam logic [15:0] RST_VCO_CURR_CAL = 16'h0600;
  localparam logic [4:0] RST_ARRAY_RESULT = 5'h10;
  localparam logic [5:0] RST_CURRENT_RESULT = 6'h20;
  localparam logic [15:0] REG_RESET [N_REGS] = '{RST_GAIN_MODE_THR,
    RST_GAIN_LOOP_TUNE, RST_FE_GAIN_STEPS, RST_VCO_ARRAY_CAL,
    RST_VCO_CAL_CTRL, RST_VCO_CURR_CAL};
  localparam logic [15:0] REG_WMASK [N_REGS] = '{16'hFFFF, 16'h7FFF,
    16'h03FF, 16'h0FE0, 16'hFFFF, 16'h7FC0};

  // ----------------------------------------
  // Field positions (lsb)
  // ----------------------------------------
  localparam int HYST_LSB = 12;
  localparam int THR_H_LSB = 6;
  localparam int THR_L_LSB = 0;
  localparam int BLANK_SEL_BIT = 14;
  localparam int PEAK_BOOST_BIT = 13;
  localparam int SETTLE_WAIT_LSB = 11;
  localparam int PEAK_EN_LSB = 8;
  localparam int WIN_SIZE_LSB = 6;
  localparam int TARGET_LSB = 0;
  localparam int M2H_DELTA_LSB = 5;
  localparam int L2M_DELTA_LSB = 0;
  localparam int LONG_SETTLE_BIT = 11;
  localparam int ARRAY_OE_BIT = 10;
  localparam int ARRAY_OVR_LSB = 5;
  localparam int ARRAY_RES_LSB = 0;
  localparam int SKIP_TX_CAL_BIT = 15;
  localparam int LONG_MEAS_BIT = 14;
  localparam int CUR_REF_LSB = 10;
  localparam int CUR_CONST_LSB = 4;
  localparam int DAC_SEL_BIT = 3;
  localparam int DAC_VAL_LSB = 0;
  localparam int CUR_SPEED_LSB = 13;
  localparam int CUR_OE_BIT = 12;
  localparam int CUR_A_LSB = 6;
  localparam int CUR_RES_LSB = 0;
  localparam logic [6:0] WIN_BASE_LEN = 7'h08;

  // ----------------------------------------
  // Calibration timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_SHORT_US = 37;
  localparam int CAL_MEAS_US = 20;
  localparam int CAL_SETTLE_US = CAL_SHORT_US - CAL_MEAS_US;
  localparam int CAL_SETTLE_CYC = (CAL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_MEAS_CYC = (CAL_MEAS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_SETTLE = 2'b01,
    CAL_MEAS = 2'b10
  } asct_cal_state_t;

endpackage

// *** hdl/asct_regs.sv ***
// Gain loop and VCO calibration test register bank with calibration timer
//
// Overview of operation
// - Four-bit front-end gain hysteresis at 15:12, reset 3, 2 dB steps.
// - Six-bit medium/high gain switching threshold at 11:6, reset 25.
// - Six-bit low/medium gain switching threshold at 5:0, reset 9.
// - Blanking on stage removal or never; under manual override follows the bit.
// - Two-bit gain settle wait at 12:11, reset 1.
// - Three peak detector enables at 10:8, reset 0, one bit each.
// - Accumulate window 8, 16, 32 or 64 samples from bits 7:6, reset 1.
// - Six-bit gain loop target at 5:0, reset 20.
// - Five-bit medium-to-high gain delta at 9:5, reset 9.
// - Five-bit low-to-medium gain delta at 4:0, reset 10.
// - Long settle bit doubles VCO settle time during calibration.
// - Array override enable applies override value instead of calibrated array.
// - Read-only array result returns last calibration, reset 16.
// - Calibrate on RX or TX entry; with skip set, RX or strobe only.
// - Long measure bit doubles measuring; total 57 us set, 37 us clear.
// - Four-bit current calibration reference at 13:10, reset 4.
// - Six-bit current constant at 9:4, also current B override value.
// - Tuning source select bit 3 and DAC value at 2:0, reset 2.
// - Two-bit current calibration speed; code 3 undefined.
// - Current override enable uses manual current A from 11:6, reset 24.
// - Read-only current result returns last calibration, reset 32.
// - Manual gain override replaces loop gain during reception.
`timescale 1ns/1ns

module asct_regs
  import asct_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_HIT,
  input wire logic MAN_GAIN_OE,
  input wire logic [6:0] MAN_GAIN_VALUE,
  input wire logic [6:0] LOOP_GAIN_VALUE,
  input wire logic RX_ACTIVE,
  input wire logic STAGE_REMOVED,
  input wire logic ENTER_RX,
  input wire logic ENTER_TX,
  input wire logic TX_CAL_STROBE,
  input wire logic [4:0] CAL_ARRAY_IN,
  input wire logic [5:0] CAL_CURRENT_IN,
  output logic [3:0] FE_GAIN_HYST,
  output logic [5:0] MED_HIGH_THR,
  output logic [5:0] LOW_MED_THR,
  output logic BLANK_REQ,
  output logic [1:0] GAIN_SETTLE_WAIT,
  output logic PEAK_BIAS_BOOST,
  output logic [2:0] PEAK_DET_EN,
  output logic [6:0] ACC_WINDOW_LEN,
  output logic [5:0] GAIN_LOOP_TARGET,
  output logic [4:0] MED_HIGH_DELTA,
  output logic [4:0] LOW_MED_DELTA,
  output logic [6:0] VGA_GAIN_USED,
  output logic [4:0] VCO_ARRAY_USED,
  output logic TUNE_FROM_DAC,
  output logic [2:0] TUNE_DAC_VALUE,
  output logic [3:0] CUR_CAL_REF,
  output logic [5:0] CUR_CAL_CONST,
  output logic [1:0] CUR_CAL_SPEED,
  output logic CURRENT_OVERRIDE,
  output logic [5:0] CURRENT_A_USED,
  output logic CAL_BUSY,
  output logic CAL_DONE
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic addr_hit;
  logic [5:0] addr_off;
  logic [2:0] idx;

  always_comb begin
    addr_off = REG_ADDR - ADDR_GAIN_MODE_THR;
    addr_hit = (REG_ADDR >= ADDR_GAIN_MODE_THR) && (REG_ADDR <= ADDR_VCO_CURR_CAL);
    idx = addr_off[2:0];
  end

  // ----------------------------------------
  // Writable register storage
  // ----------------------------------------
  logic [15:0] regs_r [N_REGS];
  logic [15:0] regs_nxt [N_REGS];

  genvar g;
  generate
    for (g = 0; g < N_REGS; g++) begin : g_reg
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (REG_WR && addr_hit && (idx == 3'(g))) begin
          // Result and reserved bits never stored
          regs_nxt[g] = REG_WDATA & REG_WMASK[g];
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
          regs_r[g] <= REG_RESET[g];
        end else begin
          regs_r[g] <= regs_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  logic blank_sel;
  logic array_oe;
  logic [4:0] array_ovr;
  logic skip_tx_cal;
  logic long_meas;
  logic long_settle;
  logic cur_oe;
  logic [5:0] cur_a_ovr;
  logic [1:0] win_code;

  assign FE_GAIN_HYST = regs_r[0][HYST_LSB +: 4];
  assign MED_HIGH_THR = regs_r[0][THR_H_LSB +: 6];
  assign LOW_MED_THR = regs_r[0][THR_L_LSB +: 6];
  assign blank_sel = regs_r[1][BLANK_SEL_BIT];
  assign PEAK_BIAS_BOOST = regs_r[1][PEAK_BOOST_BIT];
  assign GAIN_SETTLE_WAIT = regs_r[1][SETTLE_WAIT_LSB +: 2];
  assign PEAK_DET_EN = regs_r[1][PEAK_EN_LSB +: 3];
  assign win_code = regs_r[1][WIN_SIZE_LSB +: 2];
  assign GAIN_LOOP_TARGET = regs_r[1][TARGET_LSB +: 6];
  assign MED_HIGH_DELTA = regs_r[2][M2H_DELTA_LSB +: 5];
  assign LOW_MED_DELTA = regs_r[2][L2M_DELTA_LSB +: 5];
  assign long_settle = regs_r[3][LONG_SETTLE_BIT];
  assign array_oe = regs_r[3][ARRAY_OE_BIT];
  assign array_ovr = regs_r[3][ARRAY_OVR_LSB +: 5];
  assign skip_tx_cal = regs_r[4][SKIP_TX_CAL_BIT];
  assign long_meas = regs_r[4][LONG_MEAS_BIT];
  assign CUR_CAL_REF = regs_r[4][CUR_REF_LSB +: 4];
  assign CUR_CAL_CONST = regs_r[4][CUR_CONST_LSB +: 6];
  assign TUNE_FROM_DAC = regs_r[4][DAC_SEL_BIT];
  assign TUNE_DAC_VALUE = regs_r[4][DAC_VAL_LSB +: 3];
  assign CUR_CAL_SPEED = regs_r[5][CUR_SPEED_LSB +: 2];
  assign cur_oe = regs_r[5][CUR_OE_BIT];
  assign cur_a_ovr = regs_r[5][CUR_A_LSB +: 6];
  assign CURRENT_OVERRIDE = cur_oe;

  // ----------------------------------------
  // Calibration sequencer
  // ----------------------------------------
  asct_cal_state_t cal_state_r;
  asct_cal_state_t cal_state_nxt;
  logic [9:0] cal_cnt_r;
  logic [9:0] cal_cnt_nxt;
  logic meas_long_r;
  logic meas_long_nxt;
  logic cal_trig;
  logic cal_end;

  // Calibration sources depend on the skip bit
  assign cal_trig = ENTER_RX || (ENTER_TX && !skip_tx_cal) || (TX_CAL_STROBE && skip_tx_cal);

  always_comb begin
    cal_state_nxt = cal_state_r;
    cal_cnt_nxt = cal_cnt_r;
    meas_long_nxt = meas_long_r;
    cal_end = 1'b0;
    case (cal_state_r)
      CAL_IDLE: begin
        if (cal_trig) begin
          cal_state_nxt = CAL_SETTLE;
          meas_long_nxt = long_meas;
          cal_cnt_nxt = long_settle ? 10'(2 * CAL_SETTLE_CYC - 1) : 10'(CAL_SETTLE_CYC - 1);
        end
      end
      CAL_SETTLE: begin
        if (cal_cnt_r == 10'h000) begin
          cal_state_nxt = CAL_MEAS;
          cal_cnt_nxt = meas_long_r ? 10'(2 * CAL_MEAS_CYC - 1) : 10'(CAL_MEAS_CYC - 1);
        end else begin
          cal_cnt_nxt = cal_cnt_r - 10'h001;
        end
      end
      CAL_MEAS: begin
        if (cal_cnt_r == 10'h000) begin
          cal_state_nxt = CAL_IDLE;
          cal_end = 1'b1;
        end else begin
          cal_cnt_nxt = cal_cnt_r - 10'h001;
        end
      end
      default: begin
        cal_state_nxt = CAL_IDLE;
        cal_cnt_nxt = 10'h000;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      cal_state_r <= CAL_IDLE;
      cal_cnt_r <= 10'h000;
      meas_long_r <= 1'b0;
    end else begin
      cal_state_r <= cal_state_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      meas_long_r <= meas_long_nxt;
    end
  end

  assign CAL_BUSY = (cal_state_r != CAL_IDLE);

  // ----------------------------------------
  // Calibration results and applied values
  // ----------------------------------------
  logic [4:0] array_res_r;
  logic [4:0] array_res_nxt;
  logic [5:0] cur_res_r;
  logic [5:0] cur_res_nxt;
  logic done_r;
  logic blank_r;
  logic blank_nxt;
  logic [6:0] vga_r;
  logic [6:0] vga_nxt;
  logic [4:0] arr_used_r;
  logic [4:0] arr_used_nxt;
  logic [5:0] cur_used_r;
  logic [5:0] cur_used_nxt;
  logic [6:0] win_r;
  logic [6:0] win_nxt;

  always_comb begin
    // Only the sequencer updates results
    array_res_nxt = cal_end ? CAL_ARRAY_IN : array_res_r;
    cur_res_nxt = cal_end ? CAL_CURRENT_IN : cur_res_r;
    if (MAN_GAIN_OE) begin
      blank_nxt = blank_sel;
    end else begin
      blank_nxt = !blank_sel && STAGE_REMOVED;
    end
    vga_nxt = (MAN_GAIN_OE && RX_ACTIVE) ? MAN_GAIN_VALUE : LOOP_GAIN_VALUE;
    arr_used_nxt = array_oe ? array_ovr : array_res_r;
    cur_used_nxt = cur_oe ? cur_a_ovr : cur_res_r;
    win_nxt = WIN_BASE_LEN << win_code;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      array_res_r <= RST_ARRAY_RESULT;
      cur_res_r <= RST_CURRENT_RESULT;
      done_r <= 1'b0;
      blank_r <= 1'b0;
      vga_r <= 7'h00;
      arr_used_r <= RST_ARRAY_RESULT;
      cur_used_r <= RST_CURRENT_RESULT;
      win_r <= 7'h10;
    end else begin
      array_res_r <= array_res_nxt;
      cur_res_r <= cur_res_nxt;
      done_r <= cal_end;
      blank_r <= blank_nxt;
      vga_r <= vga_nxt;
      arr_used_r <= arr_used_nxt;
      cur_used_r <= cur_used_nxt;
      win_r <= win_nxt;
    end
  end

  assign CAL_DONE = done_r;
  assign BLANK_REQ = blank_r;
  assign VGA_GAIN_USED = vga_r;
  assign VCO_ARRAY_USED = arr_used_r;
  assign CURRENT_A_USED = cur_used_r;
  assign ACC_WINDOW_LEN = win_r;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    hit_nxt = hit_r;
    if (REG_RD) begin
      hit_nxt = addr_hit;
      rdata_nxt = 16'h0000;
      if (addr_hit) begin
        rdata_nxt = regs_r[idx];
        if (idx == 3'h3) begin
          rdata_nxt[ARRAY_RES_LSB +: 5] = array_res_r;
        end
        if (idx == 3'h5) begin
          rdata_nxt[CUR_RES_LSB +: 6] = cur_res_r;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_r <= 16'h0000;
      hit_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign REG_HIT = hit_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  int unsigned busy_len;
  int unsigned exp_len;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !CAL_BUSY) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
    if (!CAL_BUSY) begin
      exp_len <= (long_settle ? 2 : 1) * CAL_SETTLE_CYC + (long_meas ? 2 : 1) * CAL_MEAS_CYC;
    end
  end

  chk_hyst_reset: assert property (@(posedge SYS_CLK) SYS_RST |=> FE_GAIN_HYST == 4'h3 && MED_HIGH_THR == 6'h19)
    else $error("gain mode thresholds wrong after reset");

  chk_thr_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    REG_WR && REG_ADDR == ADDR_GAIN_MODE_THR |=>
      MED_HIGH_THR == $past(REG_WDATA[11:6]) && LOW_MED_THR == $past(REG_WDATA[5:0]))
    else $error("threshold write not applied");

  chk_blank_auto: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !MAN_GAIN_OE && !blank_sel && STAGE_REMOVED |=> BLANK_REQ)
    else $error("blanking missing on stage removal");

  chk_blank_manual: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    MAN_GAIN_OE && !blank_sel ##1 MAN_GAIN_OE |-> !BLANK_REQ)
    else $error("blanking under override with bit clear");

  chk_win_len: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    win_code == 2'h3 |=> ACC_WINDOW_LEN == 7'h40 || $past(win_code, 1) != win_code)
    else $error("window length not 64");

  chk_skip_tx: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !CAL_BUSY && skip_tx_cal && ENTER_TX && !ENTER_RX && !TX_CAL_STROBE |=> !CAL_BUSY)
    else $error("calibration started on skipped transmit entry");

  chk_cal_length: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CAL_DONE |-> busy_len == exp_len)
    else $error("calibration length wrong");

  chk_array_result: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CAL_DONE && !array_oe ##1 !array_oe |-> VCO_ARRAY_USED == $past(CAL_ARRAY_IN, 2))
    else $error("array result not applied");

  chk_ro_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    REG_WR && REG_ADDR == ADDR_VCO_CURR_CAL && !cal_end |=> $stable(cur_res_r))
    else $error("current result changed by write");

  chk_cur_override: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    cur_oe ##1 cur_oe && $stable(cur_a_ovr) |-> CURRENT_A_USED == cur_a_ovr)
    else $error("current override not applied");

  cov_rx_cal: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) ENTER_RX && !CAL_BUSY ##1 CAL_BUSY);
  cov_long_cal: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) CAL_DONE && busy_len == 570);
  cov_strobe_cal: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) TX_CAL_STROBE && skip_tx_cal && !CAL_BUSY);
  cov_blank: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) BLANK_REQ);

endmodule

// *** dv/asct_host.sv ***
// Host model that issues register writes and reads to the test register bank
`timescale 1ns/1ns

module asct_host
  import asct_pkg::*;
(
  input wire logic clk,
  output logic [5:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic hit
);
  // ----------------------------------------
  // Reserved bits kept at zero on every write
  // ----------------------------------------
  function automatic logic [15:0] rsvd(input logic [5:0] a);
    case (a)
      ADDR_GAIN_LOOP_TUNE, ADDR_VCO_CURR_CAL: rsvd = 16'h8000;
      ADDR_FE_GAIN_STEPS: rsvd = 16'hFC00;
      ADDR_VCO_ARRAY_CAL: rsvd = 16'hF000;
      default: rsvd = 16'h0000;
    endcase
  endfunction

  initial begin
    addr = 6'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  // ----------------------------------------
  // Bus cycles, optional idle gap before each
  // ----------------------------------------
  task automatic do_wr(input logic [5:0] a, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    wdata <= d & ~rsvd(a);
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~(d & ~rsvd(a));
  endtask

  task automatic do_rd(input logic [5:0] a, input int gap, output logic [15:0] d, output logic h);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    h = hit;
  endtask
endmodule

// *** dv/test_agc_synth_cal_test_regs.sv ***
// Self-checking bench for the gain loop and VCO calibration register bank
`timescale 1ns/1ns

module test_agc_synth_cal_test_regs
  import asct_pkg::*;
;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [5:0] REG_ADDR;
  logic REG_WR, REG_RD, REG_HIT;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic MAN_GAIN_OE = 1'b0, RX_ACTIVE = 1'b0, STAGE_REMOVED = 1'b0;
  logic ENTER_RX = 1'b0, ENTER_TX = 1'b0, TX_CAL_STROBE = 1'b0;
  logic [6:0] MAN_GAIN_VALUE = 7'h00, LOOP_GAIN_VALUE = 7'h00;
  logic [4:0] CAL_ARRAY_IN = 5'h00;
  logic [5:0] CAL_CURRENT_IN = 6'h00;
  logic [3:0] FE_GAIN_HYST, CUR_CAL_REF;
  logic [5:0] MED_HIGH_THR, LOW_MED_THR, GAIN_LOOP_TARGET, CUR_CAL_CONST, CURRENT_A_USED;
  logic [4:0] MED_HIGH_DELTA, LOW_MED_DELTA, VCO_ARRAY_USED;
  logic [6:0] ACC_WINDOW_LEN, VGA_GAIN_USED;
  logic [2:0] PEAK_DET_EN, TUNE_DAC_VALUE;
  logic [1:0] GAIN_SETTLE_WAIT, CUR_CAL_SPEED;
  logic BLANK_REQ, PEAK_BIAS_BOOST, TUNE_FROM_DAC, CURRENT_OVERRIDE, CAL_BUSY, CAL_DONE;

  // ----------------------------------------
  // Reference model and bookkeeping
  // ----------------------------------------
  logic [15:0] m [6] = '{16'h3649, 16'h0854, 16'h012A, 16'h0210, 16'h5002, 16'h0620};
  localparam logic [15:0] WM [6] = '{16'hFFFF, 16'h7FFF, 16'h03FF, 16'h0FE0, 16'hFFFF, 16'h7FC0};
  localparam int KIND [5] = '{0, 1, 1, 2, 2};
  localparam bit SKIP [5] = '{1, 0, 1, 1, 0};
  localparam bit CALS [5] = '{1, 1, 0, 1, 0};
  logic [15:0] lfsr = 16'h0056;
  int bad_count = 0;
  int check_count = 0;

  initial begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  asct_regs dut (.SYS_CLK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .REG_HIT,
    .MAN_GAIN_OE, .MAN_GAIN_VALUE, .LOOP_GAIN_VALUE, .RX_ACTIVE, .STAGE_REMOVED, .ENTER_RX, .ENTER_TX,
    .TX_CAL_STROBE, .CAL_ARRAY_IN, .CAL_CURRENT_IN, .FE_GAIN_HYST, .MED_HIGH_THR, .LOW_MED_THR,
    .BLANK_REQ, .GAIN_SETTLE_WAIT, .PEAK_BIAS_BOOST, .PEAK_DET_EN, .ACC_WINDOW_LEN, .GAIN_LOOP_TARGET,
    .MED_HIGH_DELTA, .LOW_MED_DELTA, .VGA_GAIN_USED, .VCO_ARRAY_USED, .TUNE_FROM_DAC, .TUNE_DAC_VALUE,
    .CUR_CAL_REF, .CUR_CAL_CONST, .CUR_CAL_SPEED, .CURRENT_OVERRIDE, .CURRENT_A_USED, .CAL_BUSY, .CAL_DONE);

  asct_host host (.clk(SYS_CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD), .wdata(REG_WDATA),
    .rdata(REG_RDATA), .hit(REG_HIT));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wreg(input int i, input logic [15:0] d);
    host.do_wr(ADDR_GAIN_MODE_THR + 6'(i), d, i % 2);
    m[i] = (m[i] & ~WM[i]) | (d & WM[i]);
  endtask

  task automatic rd_all();
    logic [15:0] d;
    logic h;
    for (int i = 0; i < 6; i++) begin
      host.do_rd(ADDR_GAIN_MODE_THR + 6'(i), 0, d, h);
      check("read", m[i], d);
      check("hit", 16'h0001, 16'(h));
    end
    host.do_rd(6'h2A, 1, d, h);
    check("unmapped", 16'h0000, d | 16'(h));
  endtask

  task automatic chk_fields();
    @(posedge SYS_CLK);
    #1;
    check("thr", m[0], {FE_GAIN_HYST, MED_HIGH_THR, LOW_MED_THR});
    check("tune", 16'(m[1][13:8]), 16'({PEAK_BIAS_BOOST, GAIN_SETTLE_WAIT, PEAK_DET_EN}));
    check("target", 16'(m[1][5:0]), 16'(GAIN_LOOP_TARGET));
    check("window", 16'h0008 << m[1][7:6], 16'(ACC_WINDOW_LEN));
    check("steps", 16'(m[2][9:0]), 16'({MED_HIGH_DELTA, LOW_MED_DELTA}));
    check("array", 16'(m[3][10] ? m[3][9:5] : m[3][4:0]), 16'(VCO_ARRAY_USED));
    check("ctrl", 16'(m[4][13:0]), 16'({CUR_CAL_REF, CUR_CAL_CONST, TUNE_FROM_DAC, TUNE_DAC_VALUE}));
    check("speed", 16'(m[5][14:12]), 16'({CUR_CAL_SPEED, CURRENT_OVERRIDE}));
    check("current", 16'(m[5][12] ? m[5][11:6] : m[5][5:0]), 16'(CURRENT_A_USED));
    check("idle", 16'h0000, 16'(CAL_BUSY));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    int n;
    repeat (3) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    chk_fields();
    rd_all();
    for (int k = 0; k < 24; k++) begin
      d = rnd();
      if (k % 6 == 1) d[7:6] = 2'(k / 6);
      if (k % 6 == 5 && d[14:13] == 2'h3) d[13] = 1'b0;
      wreg(k % 6, d);
      chk_fields();
    end
    rd_all();
    for (int j = 0; j < 16; j++) begin
      if (j % 8 == 0) wreg(1, {m[1][15], j[3], m[1][13:0]});
      @(posedge SYS_CLK);
      d = rnd();
      MAN_GAIN_OE <= j[0];
      STAGE_REMOVED <= j[1];
      RX_ACTIVE <= j[2];
      MAN_GAIN_VALUE <= d[6:0];
      LOOP_GAIN_VALUE <= d[13:7];
      @(posedge SYS_CLK);
      STAGE_REMOVED <= 1'b0;
      #1;
      check("blank", 16'(j[0] ? j[3] : !j[3] && j[1]), 16'(BLANK_REQ));
      check("vga", 16'(j[0] && j[2] ? d[6:0] : d[13:7]), 16'(VGA_GAIN_USED));
    end
    for (int c = 0; c < 5; c++) begin
      wreg(3, rnd() & 16'h0FFF);
      d = rnd();
      wreg(4, {SKIP[c], d[14:0]});
      d = rnd();
      @(posedge SYS_CLK);
      CAL_ARRAY_IN <= d[4:0];
      CAL_CURRENT_IN <= d[10:5];
      ENTER_RX <= (KIND[c] == 0);
      ENTER_TX <= (KIND[c] == 1);
      TX_CAL_STROBE <= (KIND[c] == 2);
      @(posedge SYS_CLK);
      ENTER_RX <= 1'b0;
      ENTER_TX <= 1'b0;
      TX_CAL_STROBE <= 1'b0;
      #1;
      check("start", 16'(CALS[c]), 16'(CAL_BUSY));
      n = 1;
      while (CAL_BUSY === 1'b1 && n < 2000) begin
        @(posedge SYS_CLK);
        ENTER_RX <= (n == 5);
        #1;
        if (CAL_BUSY === 1'b1) n++;
      end
      if (n >= 2000) begin
        bad_count++;
        break;
      end
      if (CALS[c]) begin
        check("length", 16'((m[3][11] ? 340 : 170) + (m[4][14] ? 400 : 200)), 16'(n));
        check("done", 16'h0001, 16'(CAL_DONE));
        m[3][4:0] = d[4:0];
        m[5][5:0] = d[10:5];
      end
      chk_fields();
      rd_all();
    end
    test_done();
  end
endmodule
